// ===== rtl/mts_consts.svh
// Constants for the memory transfer cycle sequencer
`ifndef MTS_CONSTS_SVH
`define MTS_CONSTS_SVH

// --------------------------------------------------------------
// Address offsets from the instruction address
// --------------------------------------------------------------
`define MTS_PREFETCH_OFS 32'h8
`define MTS_NEXT_OFS 32'hc
`define MTS_WORD_OFS 32'h4

// --------------------------------------------------------------
// Register indices and reset values
// --------------------------------------------------------------
`define MTS_PC_IDX 4'hf
`define MTS_LINK_IDX 4'he
`define MTS_ZERO_IDX 4'h0
`define MTS_RESET_ADDR 32'h0
`define MTS_EMPTY_LIST 16'h0

// --------------------------------------------------------------
// Timing counts
// --------------------------------------------------------------
// Cycles waited after the request before handshake lines are trusted
`define MTS_CP_SETTLE 2'h3
`define MTS_CP_CNT_ZERO 2'h0
`define MTS_CP_CNT_STEP 2'h1

`endif

// ===== rtl/mts_pkg.sv
// Types shared by the memory transfer cycle sequencer
package mts_pkg;

   // Instruction classes the sequencer runs
   typedef enum logic [2:0] {
      OP_STR,
      OP_LDM,
      OP_STM,
      OP_EXC,
      OP_CDP
   } op_t;

   // Exception kinds, selecting the saved return address
   typedef enum logic [2:0] {
      EXC_RESET,
      EXC_UNDEF,
      EXC_SWI,
      EXC_PABORT,
      EXC_DABORT,
      EXC_IRQ,
      EXC_FIQ
   } exc_t;

   // Sequencer states
   typedef enum logic [3:0] {
      S_IDLE,
      S_FIRST,
      S_STR_XFER,
      S_MULTI_XFER,
      S_LDM_FINAL,
      S_REFILL1,
      S_REFILL2,
      S_EXC2,
      S_EXC3,
      S_CP_WAIT
   } seq_state_t;

   // Whole state of the sequencer, outputs included
   typedef struct packed {
      seq_state_t st;
      op_t op;
      exc_t exc;
      logic [31:0] pc;
      logic [15:0] list;
      logic [31:0] addr;
      logic [31:0] target;
      logic write_back;
      logic base_is_pc;
      logic byte_op;
      logic aborted;
      logic first_xfer;
      logic [3:0] prev_idx;
      logic [1:0] cp_cnt;
      logic cpa_s1;
      logic cpa_s2;
      logic cpb_s1;
      logic cpb_s2;
      logic [31:0] address;
      logic mem_write;
      logic byte_n;
      logic sequential_address;
      logic memory_request_n;
      logic opcode_fetch_n;
      logic coprocessor_instr_n;
      logic [3:0] store_idx;
      logic reg_write_en;
      logic [3:0] reg_write_idx;
      logic base_write_en;
      logic base_restore;
      logic link_write;
      logic [31:0] link_value;
      logic link_adjust;
      logic mode_change;
      exc_t trap_kind;
      logic pipeline_flush;
      logic busy;
      logic done;
   } seq_regs_t;

endpackage

// ===== rtl/reg_list_scan.sv
// Lowest-first scan of a register list
`timescale 1ns/10ps

module reg_list_scan (
   // List in
   input wire logic [15:0] list,
   // Scan results
   output logic [3:0] first_idx,
   output logic [15:0] rest,
   output logic any,
   output logic only_one
);

   logic [15:0] lowest;
   logic [3:0] acc [0:16];

   // Isolate the lowest set bit; the program counter bit is always found last
   assign lowest = list & (~list + 16'h1);
   assign rest = list & ~lowest;
   assign any = |list;
   assign only_one = any && (rest == 16'h0);
   assign acc[0] = 4'h0;

   // Encode the isolated bit into an index
   for (genvar i = 0; i < 16; i++) begin : g_enc
      assign acc[i + 1] = acc[i] | (lowest[i] ? 4'(i) : 4'h0);
   end

   assign first_idx = acc[16];

endmodule

// ===== rtl/memory_transfer_cycle_sequencer.sv
// Bus cycle sequencer for stores, block transfers, trap entry and coprocessor operations
`timescale 1ns/10ps

`include "mts_consts.svh"

module memory_transfer_cycle_sequencer
   import mts_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Instruction request from the pipeline
   input wire logic start,
   input wire op_t op_kind,
   input wire exc_t exc_kind,
   input wire logic [31:0] instr_addr,
   input wire logic [15:0] reg_list,
   input wire logic write_back,
   input wire logic base_is_pc,
   input wire logic byte_op,
   // Datapath values
   input wire logic [31:0] alu_addr,
   input wire logic [31:0] new_base,
   input wire logic [31:0] trap_addr,
   input wire logic [31:0] read_data,
   // Memory response
   input wire logic data_abort,
   // Coprocessor handshake pins
   input wire logic coprocessor_absent,
   input wire logic coprocessor_busy,
   // Memory bus
   output logic [31:0] address,
   output logic mem_write,
   output logic byte_n,
   output logic sequential_address,
   output logic memory_request_n,
   output logic opcode_fetch_n,
   output logic coprocessor_instr_n,
   // Datapath control
   output logic [3:0] store_idx,
   output logic reg_write_en,
   output logic [3:0] reg_write_idx,
   output logic base_write_en,
   output logic base_restore,
   output logic link_write,
   output logic [31:0] link_value,
   output logic link_adjust,
   output logic mode_change,
   output exc_t trap_kind,
   output logic pipeline_flush,
   // Status
   output logic busy,
   output logic done
);

   seq_regs_t s;
   seq_regs_t next_s;

   logic [3:0] cur_idx;
   logic [15:0] cur_rest;
   logic cur_any;
   logic cur_last;
   logic [3:0] nxt_idx;
   logic nxt_last;

   // --------------------------------------------------------------
   // Register list scanning
   // --------------------------------------------------------------
   // Word transferred in this cycle
   reg_list_scan u_scan_cur (
      .list(s.list),
      .first_idx(cur_idx),
      .rest(cur_rest),
      .any(cur_any),
      .only_one(cur_last)
   );

   // Word transferred in the following cycle
   reg_list_scan u_scan_nxt (
      .list(cur_rest),
      .first_idx(nxt_idx),
      .rest(),
      .any(),
      .only_one(nxt_last)
   );

   // --------------------------------------------------------------
   // Return address by trap kind
   // --------------------------------------------------------------
   function automatic logic [31:0] return_addr(input exc_t kind, input logic [31:0] pc);
      logic [31:0] ret;
      ret = pc + `MTS_WORD_OFS;
      if (kind == EXC_SWI || kind == EXC_PABORT) begin
         ret = pc;
      end
      return ret;
   endfunction

   // --------------------------------------------------------------
   // Next state and outputs
   // --------------------------------------------------------------
   always_comb begin
      logic abort_now;
      abort_now = s.aborted | data_abort;
      next_s = s;
      // One-cycle strobes fall back each cycle
      next_s.reg_write_en = 1'b0;
      next_s.base_write_en = 1'b0;
      next_s.base_restore = 1'b0;
      next_s.link_write = 1'b0;
      next_s.link_adjust = 1'b0;
      next_s.mode_change = 1'b0;
      next_s.pipeline_flush = 1'b0;
      next_s.done = 1'b0;
      // Handshake pin synchronisers
      next_s.cpa_s1 = coprocessor_absent;
      next_s.cpa_s2 = s.cpa_s1;
      next_s.cpb_s1 = coprocessor_busy;
      next_s.cpb_s2 = s.cpb_s1;

      unique case (s.st)
         S_IDLE: begin
            if (start) begin
               next_s.st = S_FIRST;
               next_s.op = op_kind;
               next_s.exc = exc_kind;
               next_s.pc = instr_addr;
               next_s.list = reg_list;
               next_s.write_back = write_back;
               next_s.base_is_pc = base_is_pc;
               next_s.byte_op = byte_op;
               next_s.aborted = 1'b0;
               next_s.first_xfer = 1'b1;
               next_s.cp_cnt = `MTS_CP_CNT_ZERO;
               if (op_kind == OP_EXC) begin
                  next_s.mode_change = 1'b1;
                  next_s.link_write = 1'b1;
                  next_s.link_value = return_addr(exc_kind, instr_addr);
                  next_s.trap_kind = exc_kind;
               end
            end
         end
         S_FIRST: begin
            // Address computed in the datapath during the prefetch
            next_s.addr = alu_addr;
            unique case (s.op)
               OP_STR: next_s.st = S_STR_XFER;
               OP_LDM, OP_STM: begin
                  next_s.st = cur_any ? S_MULTI_XFER : S_IDLE;
                  next_s.done = !cur_any;
               end
               OP_EXC: begin
                  next_s.target = trap_addr;
                  next_s.link_adjust = 1'b1;
                  next_s.st = S_EXC2;
               end
               OP_CDP: next_s.st = S_CP_WAIT;
            endcase
         end
         S_STR_XFER: begin
            // Base update only when the write did not abort
            if (!data_abort && s.write_back) begin
               next_s.base_write_en = 1'b1;
            end
            if (!data_abort && s.write_back && s.base_is_pc) begin
               next_s.target = new_base;
               next_s.pipeline_flush = 1'b1;
               next_s.st = S_REFILL1;
            end else begin
               next_s.done = 1'b1;
               next_s.st = S_IDLE;
            end
         end
         S_MULTI_XFER: begin
            // Previously fetched word goes to its register unless aborted
            if (s.op == OP_LDM && !s.first_xfer && !s.aborted) begin
               next_s.reg_write_en = 1'b1;
               next_s.reg_write_idx = s.prev_idx;
            end
            // Base modified alongside the first transfer
            if (s.first_xfer && s.write_back && !s.base_is_pc) begin
               next_s.base_write_en = (s.op == OP_LDM) || !data_abort;
            end
            if (s.op == OP_LDM && cur_idx == `MTS_PC_IDX) begin
               next_s.target = read_data;
            end
            next_s.first_xfer = 1'b0;
            next_s.aborted = abort_now;
            next_s.prev_idx = cur_idx;
            next_s.list = cur_rest;
            next_s.addr = s.addr + `MTS_WORD_OFS;
            if (cur_last) begin
               next_s.st = (s.op == OP_LDM) ? S_LDM_FINAL : S_IDLE;
               next_s.done = (s.op == OP_STM);
            end
         end
         S_LDM_FINAL: begin
            next_s.st = S_IDLE;
            next_s.done = 1'b1;
            if (s.aborted) begin
               next_s.base_restore = s.write_back && !s.base_is_pc;
            end else begin
               next_s.reg_write_en = 1'b1;
               next_s.reg_write_idx = s.prev_idx;
               if (s.prev_idx == `MTS_PC_IDX) begin
                  next_s.pipeline_flush = 1'b1;
                  next_s.done = 1'b0;
                  next_s.st = S_REFILL1;
               end
            end
         end
         S_REFILL1: next_s.st = S_REFILL2;
         S_REFILL2: begin
            next_s.done = 1'b1;
            next_s.st = S_IDLE;
         end
         S_EXC2: next_s.st = S_EXC3;
         S_EXC3: begin
            next_s.done = 1'b1;
            next_s.st = S_IDLE;
         end
         S_CP_WAIT: begin
            // Let the synchronised lines catch up with the request first
            if (s.cp_cnt != `MTS_CP_SETTLE) begin
               next_s.cp_cnt = s.cp_cnt + `MTS_CP_CNT_STEP;
            end else if (!s.cpb_s2) begin
               next_s.done = 1'b1;
               next_s.st = S_IDLE;
            end else if (s.cpa_s2) begin
               // Nobody answered: take the undefined instruction trap
               next_s.op = OP_EXC;
               next_s.exc = EXC_UNDEF;
               next_s.trap_kind = EXC_UNDEF;
               next_s.mode_change = 1'b1;
               next_s.link_write = 1'b1;
               next_s.link_value = return_addr(EXC_UNDEF, s.pc);
               next_s.st = S_FIRST;
            end
            // Absent low with busy high keeps waiting
         end
         default: next_s.st = S_IDLE;
      endcase

      // Bus outputs for the cycle being entered
      next_s.busy = (next_s.st != S_IDLE);
      next_s.mem_write = 1'b0;
      next_s.byte_n = 1'b1;
      next_s.sequential_address = 1'b0;
      next_s.memory_request_n = 1'b0;
      next_s.opcode_fetch_n = 1'b1;
      next_s.coprocessor_instr_n = 1'b1;
      unique case (next_s.st)
         S_IDLE: begin
            next_s.memory_request_n = 1'b1;
            next_s.address = next_s.pc + `MTS_NEXT_OFS;
         end
         S_FIRST: begin
            next_s.address = next_s.pc + `MTS_PREFETCH_OFS;
            next_s.opcode_fetch_n = 1'b0;
            next_s.coprocessor_instr_n = (next_s.op != OP_CDP);
         end
         S_STR_XFER: begin
            next_s.address = next_s.addr;
            next_s.mem_write = 1'b1;
            next_s.byte_n = !s.byte_op;
            next_s.store_idx = cur_idx;
         end
         S_MULTI_XFER: begin
            next_s.address = next_s.addr;
            next_s.mem_write = (s.op == OP_STM);
            next_s.store_idx = (s.st == S_FIRST) ? cur_idx : nxt_idx;
            next_s.sequential_address = (s.st == S_FIRST) ? !cur_last : !nxt_last;
         end
         S_LDM_FINAL: begin
            next_s.address = s.pc + `MTS_NEXT_OFS;
            next_s.memory_request_n = 1'b1;
            next_s.sequential_address = 1'b1;
         end
         S_REFILL1: begin
            next_s.address = next_s.target;
            next_s.opcode_fetch_n = 1'b0;
            next_s.sequential_address = 1'b1;
         end
         S_REFILL2: begin
            next_s.address = next_s.target + `MTS_WORD_OFS;
            next_s.opcode_fetch_n = 1'b0;
            next_s.sequential_address = 1'b1;
         end
         S_EXC2: begin
            next_s.address = next_s.target;
            next_s.opcode_fetch_n = 1'b0;
            next_s.sequential_address = 1'b1;
         end
         S_EXC3: begin
            next_s.address = next_s.target + `MTS_WORD_OFS;
            next_s.opcode_fetch_n = 1'b0;
            next_s.sequential_address = 1'b1;
         end
         S_CP_WAIT: begin
            next_s.address = next_s.pc + `MTS_PREFETCH_OFS;
            next_s.memory_request_n = 1'b1;
            next_s.coprocessor_instr_n = 1'b0;
         end
         default: next_s.memory_request_n = 1'b1;
      endcase
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s <= '0;
         s.st <= S_IDLE;
         s.op <= OP_STR;
         s.exc <= EXC_RESET;
         s.trap_kind <= EXC_RESET;
         s.address <= `MTS_RESET_ADDR;
         s.list <= `MTS_EMPTY_LIST;
         s.prev_idx <= `MTS_ZERO_IDX;
         s.store_idx <= `MTS_ZERO_IDX;
         s.reg_write_idx <= `MTS_ZERO_IDX;
         s.cpa_s1 <= 1'b1;
         s.cpa_s2 <= 1'b1;
         s.cpb_s1 <= 1'b1;
         s.cpb_s2 <= 1'b1;
         s.byte_n <= 1'b1;
         s.memory_request_n <= 1'b1;
         s.opcode_fetch_n <= 1'b1;
         s.coprocessor_instr_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign address = s.address;
   assign mem_write = s.mem_write;
   assign byte_n = s.byte_n;
   assign sequential_address = s.sequential_address;
   assign memory_request_n = s.memory_request_n;
   assign opcode_fetch_n = s.opcode_fetch_n;
   assign coprocessor_instr_n = s.coprocessor_instr_n;
   assign store_idx = s.store_idx;
   assign reg_write_en = s.reg_write_en;
   assign reg_write_idx = s.reg_write_idx;
   assign base_write_en = s.base_write_en;
   assign base_restore = s.base_restore;
   assign link_write = s.link_write;
   assign link_value = s.link_value;
   assign link_adjust = s.link_adjust;
   assign mode_change = s.mode_change;
   assign trap_kind = s.trap_kind;
   assign pipeline_flush = s.pipeline_flush;
   assign busy = s.busy;
   assign done = s.done;

endmodule

// ===== verif/mts_checker_asserts.sv
// Port-level checks of the memory transfer cycle sequencer
`timescale 1ns/10ps
module mts_checker
   import mts_pkg::*;
(
   // Clock, reset and requests
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire op_t op_kind,
   input wire exc_t exc_kind,
   input wire logic [31:0] instr_addr,
   input wire logic base_is_pc,
   input wire logic byte_op,
   input wire logic [31:0] alu_addr,
   input wire logic [31:0] new_base,
   input wire logic [31:0] trap_addr,
   input wire logic data_abort,
   input wire logic coprocessor_absent,
   input wire logic coprocessor_busy,
   // Watched outputs
   input wire logic [31:0] address,
   input wire logic mem_write,
   input wire logic byte_n,
   input wire logic sequential_address,
   input wire logic memory_request_n,
   input wire logic opcode_fetch_n,
   input wire logic coprocessor_instr_n,
   input wire logic base_write_en,
   input wire logic link_write,
   input wire logic link_adjust,
   input wire logic [31:0] link_value,
   input wire logic mode_change,
   input wire exc_t trap_kind,
   input wire logic pipeline_flush,
   input wire logic busy,
   input wire logic done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_go(op_t k);
      start && !busy && op_kind == k;
   endsequence
   sequence s_exc_walk;
      (mode_change && link_write && !opcode_fetch_n) ##1
      (address == trap_addr && sequential_address && link_adjust) ##1
      (address == trap_addr + 32'h4 && sequential_address) ##1 done;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_str_fetch;
      s_go(OP_STR) |=> address == $past(instr_addr) + 32'h8 && !opcode_fetch_n &&
         !memory_request_n && !sequential_address;
   endproperty
   a_str_fetch: assert property (p_str_fetch) else $error("store prefetch wrong");
   property p_str_write;
      s_go(OP_STR) ##2 1'b1 |-> mem_write && address == alu_addr &&
         byte_n == !$past(byte_op, 2);
   endproperty
   a_str_write: assert property (p_str_write) else $error("store write wrong");
   property p_str_abort;
      s_go(OP_STR) ##2 data_abort |=> !base_write_en;
   endproperty
   a_str_abort: assert property (p_str_abort) else $error("base written on abort");
   property p_str_refill;
      s_go(OP_STR) ##3 pipeline_flush |-> address == new_base && sequential_address ##1
         address == new_base + 32'h4 && sequential_address;
   endproperty
   a_str_refill: assert property (p_str_refill) else $error("store refill wrong");
   property p_ldm_fetch;
      s_go(OP_LDM) |=> address == $past(instr_addr) + 32'h8 && !opcode_fetch_n;
   endproperty
   a_ldm_fetch: assert property (p_ldm_fetch) else $error("block prefetch wrong");
   property p_burst_step;
      busy && !memory_request_n && sequential_address && opcode_fetch_n |=>
         address == $past(address) + 32'h4 && !memory_request_n;
   endproperty
   a_burst_step: assert property (p_burst_step) else $error("burst step wrong");
   property p_ldm_pc_base;
      s_go(OP_LDM) ##0 base_is_pc |=> (!base_write_en) [*8];
   endproperty
   a_ldm_pc_base: assert property (p_ldm_pc_base) else $error("pc base written");
   property p_exc_entry;
      s_go(OP_EXC) |=> address == $past(instr_addr) + 32'h8 ##0 s_exc_walk;
   endproperty
   a_exc_entry: assert property (p_exc_entry) else $error("trap entry wrong");
   property p_swi_link;
      s_go(OP_EXC) ##0 exc_kind == EXC_SWI |=> link_value == $past(instr_addr);
   endproperty
   a_swi_link: assert property (p_swi_link) else $error("trap return wrong");
   property p_cp_wait;
      (coprocessor_busy && !coprocessor_absent) [*4] ##0
         (busy && !coprocessor_instr_n && memory_request_n) |=> !done && busy;
   endproperty
   a_cp_wait: assert property (p_cp_wait) else $error("left busy wait early");
   property p_cp_undef;
      (coprocessor_busy && coprocessor_absent) [*4] ##0
         (busy && !coprocessor_instr_n && memory_request_n) |->
         ##[1:8] (mode_change && trap_kind == EXC_UNDEF);
   endproperty
   a_cp_undef: assert property (p_cp_undef) else $error("no undefined trap");
endmodule

bind memory_transfer_cycle_sequencer mts_checker chk_u (.clk, .resetn, .start, .op_kind,
   .exc_kind, .instr_addr, .base_is_pc, .byte_op, .alu_addr, .new_base, .trap_addr,
   .data_abort, .coprocessor_absent, .coprocessor_busy, .address, .mem_write, .byte_n,
   .sequential_address, .memory_request_n, .opcode_fetch_n, .coprocessor_instr_n,
   .base_write_en, .link_write, .link_adjust, .link_value, .mode_change, .trap_kind,
   .pipeline_flush, .busy, .done);

// ===== verif/cp_model.sv
// Coprocessor model answering the data operation handshake
`timescale 1ns/10ps
module cp_model (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Request and behaviour select
   input wire logic coprocessor_instr_n,
   input wire logic accept,
   input wire logic [3:0] commit_delay,
   // Handshake lines, pulled high when released
   output logic coprocessor_absent = 1'b1,
   output logic coprocessor_busy = 1'b1
);
   logic [3:0] wait_n = 4'h0;
   // Claim the operation, stall, then commit
   always @(posedge clk) begin
      if (!resetn || coprocessor_instr_n || !accept) begin
         coprocessor_absent <= 1'b1;
         coprocessor_busy <= 1'b1;
         wait_n <= 4'h0;
      end else begin
         coprocessor_absent <= 1'b0;
         if (wait_n == commit_delay) begin
            coprocessor_busy <= 1'b0;
         end else begin
            wait_n <= wait_n + 4'h1;
         end
      end
   end
endmodule

// ===== verif/memory_transfer_cycle_sequencer_tb.sv
// Self-checking bench for the memory transfer cycle sequencer
`timescale 1ns/10ps
module memory_transfer_cycle_sequencer_tb
   import mts_pkg::*;
;
   logic clk = 1'b0, resetn = 1'b0, start = 1'b0, write_back = 1'b0, base_is_pc = 1'b0;
   logic byte_op = 1'b0, data_abort = 1'b0, cp_accept = 1'b0;
   op_t op_kind = OP_STR;
   exc_t exc_kind = EXC_RESET;
   logic [15:0] reg_list = 16'h0;
   logic [31:0] instr_addr = 32'h100, alu_addr = 32'h400, new_base = 32'h800;
   logic [31:0] trap_addr = 32'h1c, read_data = 32'h2000;
   logic [31:0] address, link_value, ra0, ra1;
   logic mem_write, byte_n, sequential_address, memory_request_n, opcode_fetch_n;
   logic coprocessor_instr_n, reg_write_en, base_write_en, base_restore, link_write;
   logic link_adjust, mode_change, pipeline_flush, busy, done;
   logic coprocessor_absent, coprocessor_busy;
   logic [3:0] store_idx, reg_write_idx, lastw;
   exc_t trap_kind;
   // Pulses: 0 reg write, 1 base write, 2 restore, 3 flush, 4 mode, 5 link, 6 adjust
   int n[7];
   int fails = 0, check_count = 0, cyc = 0, t0;

   memory_transfer_cycle_sequencer dut_u (.clk, .resetn, .start, .op_kind, .exc_kind,
      .instr_addr, .reg_list, .write_back, .base_is_pc, .byte_op, .alu_addr, .new_base,
      .trap_addr, .read_data, .data_abort, .coprocessor_absent, .coprocessor_busy,
      .address, .mem_write, .byte_n, .sequential_address, .memory_request_n,
      .opcode_fetch_n, .coprocessor_instr_n, .store_idx, .reg_write_en, .reg_write_idx,
      .base_write_en, .base_restore, .link_write, .link_value, .link_adjust, .mode_change,
      .trap_kind, .pipeline_flush, .busy, .done);
   cp_model cp_u (.clk, .resetn, .coprocessor_instr_n, .accept(cp_accept),
      .commit_delay(4'h6), .coprocessor_absent, .coprocessor_busy);

   // ----------------------------------------
   // Clock, timeout and pulse monitor
   // ----------------------------------------
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         test_done;
      end
   end
   // Count strobes and remember the last two refill fetches
   always @(posedge clk) begin
      n[0] += reg_write_en;
      n[1] += base_write_en;
      n[2] += base_restore;
      n[3] += pipeline_flush;
      n[4] += mode_change;
      n[5] += link_write;
      n[6] += link_adjust;
      if (reg_write_en) lastw = reg_write_idx;
      if (!opcode_fetch_n && sequential_address && !memory_request_n) begin
         ra1 = ra0;
         ra0 = address;
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic nx;
      @(posedge clk);
      #1;
   endtask
   // Present one instruction, return in its first cycle
   task automatic go(input op_t k, input logic [15:0] l, input logic w, input logic p,
      input logic b, input exc_t e);
      @(posedge clk);
      n = '{default: 0};
      op_kind <= k;
      reg_list <= l;
      write_back <= w;
      base_is_pc <= p;
      byte_op <= b;
      exc_kind <= e;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
   endtask
   task automatic fin;
      int k = 0;
      while (done !== 1'b1 && k < 40) begin
         nx;
         k++;
      end
      chk(done, 1'b1);
      nx;
   endtask
   task automatic abort_after(input int c);
      repeat (c) @(posedge clk);
      data_abort <= 1'b1;
      @(posedge clk);
      data_abort <= 1'b0;
      #1;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_str;
      go(OP_STR, 16'h0010, 1'b1, 1'b0, 1'b1, EXC_RESET);
      chk(address, instr_addr + 32'h8);
      chk({opcode_fetch_n, memory_request_n, sequential_address}, 3'b000);
      nx;
      chk(address, alu_addr);
      chk({mem_write, byte_n}, 2'b10);
      nx;
      chk(done, 1'b1);
      fin;
      chk(n[1], 1);
      go(OP_STR, 16'h0010, 1'b1, 1'b0, 1'b0, EXC_RESET);
      abort_after(1);
      fin;
      chk(n[1], 0);
      go(OP_STR, 16'h0010, 1'b1, 1'b1, 1'b0, EXC_RESET);
      fin;
      chk(n[3], 1);
      chk(ra1, new_base);
      chk(ra0, new_base + 32'h4);
   endtask
   task automatic t_ldm;
      go(OP_LDM, 16'h8009, 1'b1, 1'b0, 1'b0, EXC_RESET);
      chk(address, instr_addr + 32'h8);
      nx;
      chk(address, alu_addr);
      nx;
      chk(base_write_en, 1'b1);
      chk(address, alu_addr + 32'h4);
      nx;
      chk({reg_write_en, reg_write_idx}, 5'h10);
      chk(sequential_address, 1'b0);
      nx;
      chk({memory_request_n, address}, {1'b1, instr_addr + 32'hc});
      fin;
      chk(n[0], 3);
      chk(lastw, 4'hf);
      chk(n[3], 1);
      chk(ra1, read_data);
      chk(ra0, read_data + 32'h4);
      go(OP_LDM, 16'h000f, 1'b1, 1'b0, 1'b0, EXC_RESET);
      abort_after(2);
      fin;
      chk(n[0], 1);
      chk(n[2], 1);
      chk(n[3], 0);
      go(OP_LDM, 16'h0003, 1'b1, 1'b1, 1'b0, EXC_RESET);
      fin;
      chk(n[1], 0);
      chk(n[0], 2);
   endtask
   task automatic t_stm;
      go(OP_STM, 16'h0006, 1'b1, 1'b0, 1'b0, EXC_RESET);
      nx;
      chk({mem_write, sequential_address, store_idx}, 6'h31);
      chk(address, alu_addr);
      nx;
      chk({mem_write, sequential_address, store_idx}, 6'h22);
      chk(address, alu_addr + 32'h4);
      nx;
      chk(done, 1'b1);
      fin;
      chk(n[0], 0);
   endtask
   task automatic t_exc;
      for (int i = 0; i < 7; i++) begin
         go(OP_EXC, 16'h0, 1'b0, 1'b0, 1'b0, exc_t'(i));
         fin;
         chk(trap_kind, exc_t'(i));
         chk(link_value, (exc_t'(i) == EXC_SWI || exc_t'(i) == EXC_PABORT) ?
            instr_addr : instr_addr + 32'h4);
         chk({n[4][0], n[5][0], n[6][0]}, 3'b111);
         chk(ra1, trap_addr);
         chk(ra0, trap_addr + 32'h4);
      end
   endtask
   task automatic t_cdp;
      @(posedge clk);
      cp_accept <= 1'b1;
      go(OP_CDP, 16'h0, 1'b0, 1'b0, 1'b0, EXC_RESET);
      t0 = cyc;
      chk({coprocessor_instr_n, address}, {1'b0, instr_addr + 32'h8});
      nx;
      chk({memory_request_n, coprocessor_instr_n}, 2'b10);
      chk(address, instr_addr + 32'h8);
      fin;
      chk(cyc - t0 > 9, 1'b1);
      chk(n[4], 0);
      @(posedge clk);
      cp_accept <= 1'b0;
      go(OP_CDP, 16'h0, 1'b0, 1'b0, 1'b0, EXC_RESET);
      fin;
      chk(trap_kind, EXC_UNDEF);
      chk(n[4], 1);
      chk(link_value, instr_addr + 32'h4);
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      nx;
      chk({memory_request_n, opcode_fetch_n, coprocessor_instr_n, byte_n, busy}, 5'h1e);
      t_str;
      t_ldm;
      t_stm;
      t_exc;
      t_cdp;
      test_done;
   end
endmodule
